/* verilog/bam_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - comparator behaviour: alarm equals OR of both protection outputs
// - interrupt behaviour: alarm holds until the flag register is read
// - hardware config picks alarm open-drain or push-pull, active level
// - protection outputs reset as active-high push-pull
// - each protection output has its own open-drain select bit
// - busy covers conversions, self-calibration, DAC math, init, amp calibration
// - serial link works regardless of busy
// - busy rises on the oscillator tick after a conversion start
// - single-conversion select: busy ends after one result is checked
// - scan selects: busy ends after the last result is checked
// - continuous mode never raises busy; leaving it raises busy until halt
// - window mode: fault when reading above high or below low
// - window mode: release only when back inside by the hysteresis
// - hysteresis mode: set above high threshold, release below it
// - window hysteresis programmable from 8 to 64 LSBs
// - limit writes take sixteen bits, top four ignored
// - stored limits read back with read command bytes
// - temperature compared as twos complement eighth-degree values
// - all registers take defaults at reset
module bam_monitor
  import bam_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic LINK_CLK,
  input wire logic LINK_CSN,
  input wire logic LINK_MOSI,
  output logic LINK_MISO,
  output logic LINK_MISO_OE_N,
  input wire logic CONVERT_START_PIN,
  input wire logic CONV_CMD,
  input wire logic OSC_TICK,
  input wire logic [1:0] CONVERSION_CLOCK_SELECT,
  input wire logic CONTINUOUS_CONVERT,
  input wire logic SELF_CAL_ACTIVE,
  input wire logic DAC_CAL_ACTIVE,
  input wire logic INIT_ACTIVE,
  input wire logic AMP_CAL_ACTIVE,
  input wire logic RESULT_VALID,
  input wire logic [1:0] RESULT_KIND,
  input wire logic [11:0] RESULT_DATA,
  input wire logic RESULT_LAST,
  output logic CHANNEL1_PROTECT_OUT,
  output logic CHANNEL1_PROTECT_OE_N,
  output logic CHANNEL2_PROTECT_OUT,
  output logic CHANNEL2_PROTECT_OE_N,
  output logic ALARM_OUT,
  output logic ALARM_OE_N,
  output logic BUSY
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0][11:0] lim;
    logic [3:0] hw_cfg;
    logic [5:0] sw_cfg;
    logic [3:0] flag;
    logic [3:0] prot;
    logic wr_seen;
    logic rd_seen;
    logic pin_q;
    logic cont_q;
    logic [15:0] rd_word;
    bam_busy_t bsy;
    logic alarm;
    logic busy;
    logic s1_out;
    logic s1_oe_n;
    logic s2_out;
    logic s2_oe_n;
    logic alm_out;
    logic alm_oe_n;
  } bam_core_t;

  // power-on defaults; alarm idles low with active-high default
  localparam bam_core_t CORE_RST = '{
    lim: LIM_RST,
    hw_cfg: HW_CFG_RST,
    sw_cfg: SW_CFG_RST,
    bsy: BS_IDLE,
    default: '0
  };

  bam_core_t s;
  bam_core_t next_s;

  // threshold command: 0x2x write or 0xAx read with even low bit
  function automatic logic is_lim(input logic [7:0] c);
    return (c[6:4] == CMD_LIM_GROUP) && !c[0];
  endfunction

  // widen a result: signed for temperature, unsigned for current
  function automatic logic signed [13:0] widen(input logic [11:0] v, input logic temp);
    return temp ? {{2{v[11]}}, v} : {2'b00, v};
  endfunction

  // ------------------------------------------------------------
  // link and pin crossings
  // ------------------------------------------------------------
  logic [23:0] wr_word;
  logic [7:0] rd_cmd;
  logic wr_tgl;
  logic rd_tgl;
  logic [2:0] sq;

  bam_link u_link (
    .link_clk(LINK_CLK),
    .link_csn(LINK_CSN),
    .rstn(RSTN),
    .mosi(LINK_MOSI),
    .rd_word(s.rd_word),
    .miso(LINK_MISO),
    .miso_oe_n(LINK_MISO_OE_N),
    .wr_word(wr_word),
    .wr_tgl(wr_tgl),
    .rd_cmd(rd_cmd),
    .rd_tgl(rd_tgl)
  );

  // toggles and the start pin are all single-bit levels here
  bam_sync #(.W(3)) u_sync (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .en(CLK_EN),
    .d({rd_tgl, wr_tgl, CONVERT_START_PIN}),
    .q(sq)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  logic wr_evt;
  logic rd_evt;
  logic flag_rd;
  logic start;
  logic cont_fall;
  logic single;
  logic chk_en;
  logic signed [13:0] rv;
  logic signed [13:0] hi;
  logic signed [13:0] lo;
  logic [13:0] hys;
  logic above;
  logic below;
  logic back_in;
  logic [3:0] set_flag;
  logic lvl;

  always_comb begin
    next_s = s;
    wr_evt = sq[1] ^ s.wr_seen;
    rd_evt = sq[2] ^ s.rd_seen;
    next_s.wr_seen = sq[1];
    next_s.rd_seen = sq[2];
    next_s.pin_q = sq[0];
    next_s.cont_q = CONTINUOUS_CONVERT;
    flag_rd = 1'b0;
    set_flag = '0;

    // register writes are taken whatever the busy state
    if (wr_evt && !wr_word[16+CMD_READ_BIT]) begin
      if (is_lim(wr_word[23:16])) begin
        next_s.lim[wr_word[19:17]] = wr_word[11:0];
      end else if (wr_word[23:16] == CMD_HW_CFG_WR) begin
        next_s.hw_cfg = wr_word[3:0];
      end else if (wr_word[23:16] == CMD_SW_CFG_WR) begin
        next_s.sw_cfg = wr_word[5:0];
      end
    end

    // read fetch; word stays still until the next read request
    if (rd_evt) begin
      if (is_lim(rd_cmd) && rd_cmd[CMD_READ_BIT]) begin
        next_s.rd_word = {4'h0, s.lim[rd_cmd[3:1]]};
      end else if (rd_cmd == CMD_HW_CFG_RD) begin
        next_s.rd_word = {12'h000, s.hw_cfg};
      end else if (rd_cmd == CMD_SW_CFG_RD) begin
        next_s.rd_word = {10'h000, s.sw_cfg};
      end else if (rd_cmd == CMD_FLAG_RD) begin
        next_s.rd_word = {12'h000, s.flag};
        flag_rd = 1'b1;
      end else begin
        next_s.rd_word = '0;
      end
    end

    // limit check on the result's own threshold pair
    rv = widen(RESULT_DATA, !RESULT_KIND[0]);
    hi = widen(s.lim[{RESULT_KIND, 1'b0}], !RESULT_KIND[0]);
    lo = widen(s.lim[{RESULT_KIND, 1'b1}], !RESULT_KIND[0]);
    hys = HYST_MIN_LSB << s.sw_cfg[SW_HYS+:2];
    above = rv > hi;
    below = rv < lo;
    back_in = (rv <= hi - $signed(hys)) && (rv >= lo + $signed(hys));
    chk_en = RESULT_VALID && (RESULT_KIND[0] ? s.sw_cfg[SW_CEN] : s.sw_cfg[SW_TEN]);
    if (chk_en) begin
      if (s.sw_cfg[SW_WIN]) begin
        if (above || below) begin
          next_s.prot[RESULT_KIND] = 1'b1;
          set_flag[RESULT_KIND] = 1'b1;
        end else if (back_in) begin
          next_s.prot[RESULT_KIND] = 1'b0;
        end
      end else begin
        if (above) begin
          next_s.prot[RESULT_KIND] = 1'b1;
          set_flag[RESULT_KIND] = 1'b1;
        end else if (rv < hi) begin
          next_s.prot[RESULT_KIND] = 1'b0;
        end
      end
    end

    // new events beat a flag read in the same cycle
    next_s.flag = (s.flag & ~{4{flag_rd}}) | set_flag;

    // channel outputs use only their own two
    next_s.s1_out = next_s.prot[0] | next_s.prot[1];
    next_s.s2_out = next_s.prot[2] | next_s.prot[3];
    next_s.alarm = s.sw_cfg[SW_INT] ? |next_s.flag
                                    : (next_s.s1_out | next_s.s2_out);

    // open-drain only pulls low; push-pull drives both ways
    next_s.s1_oe_n = next_s.hw_cfg[HW_S1_OD] & next_s.s1_out;
    next_s.s2_oe_n = next_s.hw_cfg[HW_S2_OD] & next_s.s2_out;
    if (next_s.hw_cfg[HW_S1_OD]) begin
      next_s.s1_out = 1'b0;
    end
    if (next_s.hw_cfg[HW_S2_OD]) begin
      next_s.s2_out = 1'b0;
    end
    lvl = next_s.alarm ^ ~next_s.hw_cfg[HW_ALM_AH];
    next_s.alm_out = next_s.hw_cfg[HW_ALM_OD] ? 1'b0 : lvl;
    next_s.alm_oe_n = next_s.hw_cfg[HW_ALM_OD] & lvl;

    // conversion busy tracking
    start = CONV_CMD | (sq[0] & ~s.pin_q);
    cont_fall = s.cont_q & ~CONTINUOUS_CONVERT;
    single = CONVERSION_CLOCK_SELECT == CONV_SEL_SINGLE;
    case (s.bsy)
      BS_IDLE: begin
        if (cont_fall) begin
          next_s.bsy = BS_HALT;
        end else if (start && !CONTINUOUS_CONVERT) begin
          next_s.bsy = BS_ARMED;
        end
      end
      BS_ARMED: begin
        if (OSC_TICK) begin
          next_s.bsy = BS_CONV;
        end
      end
      BS_CONV: begin
        if (RESULT_VALID && (single || RESULT_LAST)) begin
          next_s.bsy = BS_IDLE;
        end
      end
      BS_HALT: begin
        if (RESULT_VALID && RESULT_LAST) begin
          next_s.bsy = BS_IDLE;
        end
      end
      default: begin
        next_s.bsy = BS_IDLE;
      end
    endcase
    // host-side waits lean on this level
    next_s.busy = (next_s.bsy == BS_CONV) || (next_s.bsy == BS_HALT)
                  || SELF_CAL_ACTIVE || DAC_CAL_ACTIVE
                  || INIT_ACTIVE || AMP_CAL_ACTIVE;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // everything returns to its default on reset
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s <= CORE_RST;
    end else if (CLK_EN) begin
      s <= next_s;
    end
  end

  assign CHANNEL1_PROTECT_OUT = s.s1_out;
  assign CHANNEL1_PROTECT_OE_N = s.s1_oe_n;
  assign CHANNEL2_PROTECT_OUT = s.s2_out;
  assign CHANNEL2_PROTECT_OE_N = s.s2_oe_n;
  assign ALARM_OUT = s.alm_out;
  assign ALARM_OE_N = s.alm_oe_n;
  assign BUSY = s.busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  chk_alarm_or: assert property (
    !s.sw_cfg[SW_INT] && !$past(s.sw_cfg[SW_INT]) |-> s.alarm == (|s.prot))
    else $error("alarm is not the OR of protection states");

  chk_alarm_hold: assert property (
    CLK_EN && s.sw_cfg[SW_INT] && $past(s.sw_cfg[SW_INT]) && s.alarm && !flag_rd ##1 s.sw_cfg[SW_INT]
    |-> s.alarm)
    else $error("interrupt alarm dropped without a flag read");

  chk_alarm_pin: assert property (
    s.alm_oe_n == (s.hw_cfg[HW_ALM_OD] && (s.alarm == s.hw_cfg[HW_ALM_AH])))
    else $error("alarm pin drive does not match its configuration");

  chk_safe_pushpull: assert property (
    !s.hw_cfg[HW_S1_OD] |-> !s.s1_oe_n && s.s1_out == (s.prot[0] | s.prot[1]))
    else $error("channel 1 push-pull output wrong");

  chk_safe_opendrain: assert property (
    s.hw_cfg[HW_S2_OD] |-> !s.s2_out && s.s2_oe_n == (s.prot[2] | s.prot[3]))
    else $error("channel 2 open-drain output wrong");

  chk_busy_tick: assert property (
    CLK_EN && s.bsy == BS_ARMED && OSC_TICK |=> s.busy && s.bsy == BS_CONV)
    else $error("busy did not rise on oscillator tick");

  chk_busy_single: assert property (
    CLK_EN && s.bsy == BS_CONV && single && RESULT_VALID |=> s.bsy == BS_IDLE)
    else $error("single conversion did not end busy");

  chk_busy_scan: assert property (
    CLK_EN && s.bsy == BS_CONV && !single && RESULT_VALID && !RESULT_LAST |=> s.bsy == BS_CONV)
    else $error("scan ended before its last result");

  chk_cont_halt: assert property (
    CLK_EN && s.bsy == BS_IDLE && cont_fall |=> s.bsy == BS_HALT ##0 s.busy)
    else $error("leaving continuous mode did not raise busy");

  chk_window_set: assert property (
    CLK_EN && chk_en && s.sw_cfg[SW_WIN] && (above || below) |=> s.prot[$past(RESULT_KIND)])
    else $error("window fault did not set protection state");

  chk_limit_write: assert property (
    CLK_EN && wr_evt && !wr_word[23] && is_lim(wr_word[23:16])
    |=> s.lim[$past(wr_word[19:17])] == $past(wr_word[11:0]))
    else $error("limit write not stored");

  chk_prot_own: assert property (
    !chk_en |=> $stable(s.prot))
    else $error("protection state moved without a check");

  cov_single: cover property (s.bsy == BS_CONV && single && RESULT_VALID && CLK_EN);
  cov_scan: cover property (s.bsy == BS_CONV && RESULT_LAST && RESULT_VALID && CLK_EN);
  cov_halt: cover property (s.bsy == BS_HALT ##[1:200] s.bsy == BS_IDLE);
  cov_int_clear: cover property (s.sw_cfg[SW_INT] && s.alarm ##1 flag_rd ##2 !s.alarm);
endmodule
`default_nettype wire

/* verilog/bam_pkg.sv */
package bam_pkg;
  // ------------------------------------------------------------
  // serial link framing
  // ------------------------------------------------------------
  localparam logic [5:0] LINK_CMD_BITS = 6'd8;
  localparam logic [5:0] LINK_DATA_BITS = 6'd16;
  localparam logic [5:0] LINK_TURN_CLKS = 6'd8;
  localparam logic [5:0] LINK_CMD_END = LINK_CMD_BITS - 6'd1;
  localparam logic [5:0] LINK_WR_END = LINK_CMD_BITS + LINK_DATA_BITS - 6'd1;
  localparam logic [5:0] LINK_RD_LOAD = LINK_CMD_BITS + LINK_TURN_CLKS - 6'd1;
  localparam int CMD_READ_BIT = 7;

  // ------------------------------------------------------------
  // command bytes
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_LIM_GROUP = 3'h2;
  localparam logic [7:0] CMD_HW_CFG_WR = 8'h60;
  localparam logic [7:0] CMD_HW_CFG_RD = 8'he0;
  localparam logic [7:0] CMD_SW_CFG_WR = 8'h32;
  localparam logic [7:0] CMD_SW_CFG_RD = 8'hb2;
  localparam logic [7:0] CMD_FLAG_RD = 8'hea;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int HW_ALM_OD = 0;
  localparam int HW_ALM_AH = 1;
  localparam int HW_S1_OD = 2;
  localparam int HW_S2_OD = 3;
  localparam int SW_WIN = 0;
  localparam int SW_INT = 1;
  localparam int SW_TEN = 2;
  localparam int SW_CEN = 3;
  localparam int SW_HYS = 4;
  localparam logic [3:0] HW_CFG_RST = 4'h2;
  localparam logic [5:0] SW_CFG_RST = 6'h0c;
  localparam logic [11:0] LIM_TH_RST = 12'h7ff;
  localparam logic [11:0] LIM_TL_RST = 12'h800;
  localparam logic [11:0] LIM_IH_RST = 12'hfff;
  localparam logic [11:0] LIM_IL_RST = 12'h000;
  localparam logic [7:0][11:0] LIM_RST = {LIM_IL_RST, LIM_IH_RST, LIM_TL_RST, LIM_TH_RST,
                                          LIM_IL_RST, LIM_IH_RST, LIM_TL_RST, LIM_TH_RST};
  localparam logic [13:0] HYST_MIN_LSB = 14'h0008;
  localparam logic [1:0] CONV_SEL_SINGLE = 2'h3;

  typedef enum logic [1:0] {BS_IDLE, BS_ARMED, BS_CONV, BS_HALT} bam_busy_t;
endpackage

/* verilog/bam_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop level synchroniser, frozen with the clock enable
module bam_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } bam_sync_t;

  bam_sync_t s;
  bam_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.meta = d;
    next_s.q = s.meta;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (en) begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule
`default_nettype wire

/* verilog/bam_link.sv */
`timescale 1ns/1ps
`default_nettype none
// serial slave on the link clock: command byte, then 16 data bits
module bam_link
  import bam_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_csn,
  input wire logic rstn,
  input wire logic mosi,
  input wire logic [15:0] rd_word,
  output logic miso,
  output logic miso_oe_n,
  output logic [23:0] wr_word,
  output logic wr_tgl,
  output logic [7:0] rd_cmd,
  output logic rd_tgl
);
  typedef struct packed {
    logic [5:0] cnt;
    logic is_rd;
    logic [22:0] sh_in;
    logic [15:0] sh_out;
    logic miso;
    logic oe_n;
    logic [23:0] wr_word;
    logic wr_tgl;
    logic [7:0] rd_cmd;
    logic rd_tgl;
  } bam_link_t;

  bam_link_t s;
  bam_link_t next_s;

  // bits sampled and driven on the rising link edge
  always_comb begin
    next_s = s;
    next_s.sh_in = {s.sh_in[21:0], mosi};
    if (s.cnt != 6'h3f) begin
      next_s.cnt = s.cnt + 6'd1;
    end
    if (s.cnt == LINK_CMD_END) begin
      next_s.is_rd = s.sh_in[6];
      if (s.sh_in[6]) begin
        next_s.rd_cmd = {s.sh_in[6:0], mosi};
        next_s.rd_tgl = ~s.rd_tgl;
      end
    end
    // the turnaround byte gives the core time to fetch the word
    if (s.is_rd && s.cnt == LINK_RD_LOAD) begin
      next_s.miso = rd_word[15];
      next_s.sh_out = {rd_word[14:0], 1'b0};
      next_s.oe_n = 1'b0;
    end else if (s.is_rd && s.cnt > LINK_RD_LOAD) begin
      next_s.miso = s.sh_out[15];
      next_s.sh_out = {s.sh_out[14:0], 1'b0};
    end
    if (!s.is_rd && s.cnt == LINK_WR_END) begin
      next_s.wr_word = {s.sh_in, mosi};
      next_s.wr_tgl = ~s.wr_tgl;
    end
  end

  // a raised select ends the frame, since the clock may stop
  always_ff @(posedge link_clk or negedge rstn or posedge link_csn) begin
    if (!rstn) begin
      s <= '0;
      s.oe_n <= 1'b1;
    end else if (link_csn) begin
      s.cnt <= '0;
      s.is_rd <= 1'b0;
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign miso = s.miso;
  assign miso_oe_n = s.oe_n;
  assign wr_word = s.wr_word;
  assign wr_tgl = s.wr_tgl;
  assign rd_cmd = s.rd_cmd;
  assign rd_tgl = s.rd_tgl;
endmodule
`default_nettype wire

/* verif/bam_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host controller on the serial link
// ------------------------------------------------------------
module bam_host (
  output var logic link_clk,
  output var logic link_csn,
  output var logic link_mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  int oe_err = 0;
  initial begin
    link_clk = 1'b0;
    link_csn = 1'b1;
    link_mosi = 1'b0;
  end
  // clock stands still between frames; an unused data line toggles so a stale bit never looks valid
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = cmd[7] ? 32 : 24;
    rd = 16'h0000;
    link_csn = 1'b0;
    #16;
    for (int i = 0; i < n; i++) begin
      if (i < 8) link_mosi = cmd[7-i];
      else if (!cmd[7]) link_mosi = wd[23-i];  // sixteen data bits msb first
      else link_mosi = ~link_mosi;
      #16;
      if (cmd[7] && i >= 16) begin
        // a released line shows the inverse of the last bit, so it never passes by luck
        rd[31-i] = miso_oe_n ? ~miso : miso;
        if (miso_oe_n !== 1'b0) oe_err++;
      end
      link_clk = 1'b1;
      #16;
      link_clk = 1'b0;
    end
    #16;
    link_csn = 1'b1;
    link_mosi = ~link_mosi;
    #48;
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import bam_pkg::*;
;
  logic core_clk = 1'b0, rstn = 1'b0, cstart = 1'b0, conv_cmd = 1'b0, osc_tick = 1'b0, cont = 1'b0;
  logic rvalid = 1'b0, rlast = 1'b0, clk_en = 1'b1;
  logic [1:0] conv_sel = 2'h3, rkind = 2'h0;
  logic [11:0] rdata = 12'h000;
  logic [3:0] src = 4'h0;
  logic lclk, lcsn, lmosi, miso, miso_oe_n, p1, p1oe, p2, p2oe, al, aloe, busy;
  int failures = 0, comparisons = 0, seed = 32'h9ef02983;
  // ------------------------------------------------------------
  // reference model state
  // ------------------------------------------------------------
  int lim[8];
  int sw = SW_CFG_RST, hw = HW_CFG_RST;
  logic [3:0] st = 4'h0, flags = 4'h0;

  always #5 core_clk = ~core_clk;

  bam_monitor u_bam_monitor (.CORE_CLK(core_clk), .RSTN(rstn), .CLK_EN(clk_en), .LINK_CLK(lclk),
    .LINK_CSN(lcsn), .LINK_MOSI(lmosi), .LINK_MISO(miso), .LINK_MISO_OE_N(miso_oe_n),
    .CONVERT_START_PIN(cstart), .CONV_CMD(conv_cmd), .OSC_TICK(osc_tick),
    .CONVERSION_CLOCK_SELECT(conv_sel), .CONTINUOUS_CONVERT(cont), .SELF_CAL_ACTIVE(src[0]),
    .DAC_CAL_ACTIVE(src[1]), .INIT_ACTIVE(src[2]), .AMP_CAL_ACTIVE(src[3]), .RESULT_VALID(rvalid),
    .RESULT_KIND(rkind), .RESULT_DATA(rdata), .RESULT_LAST(rlast), .CHANNEL1_PROTECT_OUT(p1),
    .CHANNEL1_PROTECT_OE_N(p1oe), .CHANNEL2_PROTECT_OUT(p2), .CHANNEL2_PROTECT_OE_N(p2oe),
    .ALARM_OUT(al), .ALARM_OE_N(aloe), .BUSY(busy));
  bam_host u_bam_host (.link_clk(lclk), .link_csn(lcsn), .link_mosi(lmosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // pin levels follow from fault state, alarm behaviour and drive config
  task automatic pins_chk;
    logic a, l, c1, c2;
    c1 = |st[1:0];
    c2 = |st[3:2];
    a = sw[SW_INT] ? |flags : (c1 | c2);
    l = hw[HW_ALM_AH] ? a : ~a;
    chk({p1, p1oe, p2, p2oe, al, aloe}, {~hw[HW_S1_OD] & c1, hw[HW_S1_OD] & c1, ~hw[HW_S2_OD] & c2,
      hw[HW_S2_OD] & c2, ~hw[HW_ALM_OD] & l, hw[HW_ALM_OD] & l});
  endtask
  function automatic int val(input int x, input logic sgn);
    logic [11:0] t;
    t = x[11:0];
    return sgn ? int'($signed(t)) : int'(t);
  endfunction
  // ------------------------------------------------------------
  // link and result drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic [15:0] r;
    u_bam_host.frame(cmd, d, r);
    repeat (8) @(posedge core_clk);
    if (cmd[7:4] == 4'h2) lim[cmd[3:1]] = d[11:0];
    if (cmd == CMD_HW_CFG_WR) hw = d[3:0];
    if (cmd == CMD_SW_CFG_WR) sw = d[5:0];
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] r;
    u_bam_host.frame(cmd, 16'h0000, r);
    chk(r, exp);
  endtask
  task automatic pulse(input int which);
    @(posedge core_clk);
    if (which == 0) conv_cmd <= 1'b1;
    else osc_tick <= 1'b1;
    @(posedge core_clk);
    conv_cmd <= 1'b0;
    osc_tick <= 1'b0;
    #1;
  endtask
  // one conversion result, then the model judges it and the pins are compared
  task automatic result(input logic [1:0] k, input logic [11:0] d, input logic last);
    int v, hi, lo, h;
    @(posedge core_clk);
    rvalid <= 1'b1;
    rkind <= k;
    rdata <= d;
    rlast <= last;
    @(posedge core_clk);
    rvalid <= 1'b0;
    v = val(d, ~k[0]);  // temperature is twos complement
    hi = val(lim[2*k], ~k[0]);
    lo = val(lim[2*k+1], ~k[0]);
    h = 8 << sw[5:4];
    if (sw[SW_TEN + k[0]]) begin
      if (sw[SW_WIN]) begin
        if (v > hi || v < lo) st[k] = 1'b1;
        else if (v >= lo + h && v <= hi - h) st[k] = 1'b0;
      end else begin
        if (v > hi) st[k] = 1'b1;
        else if (v < hi) st[k] = 1'b0;
      end
      if (sw[SW_WIN] ? (v > hi || v < lo) : (v > hi)) flags[k] = 1'b1;
    end
    #1;
    pins_chk();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] r;
    for (int i = 0; i < 8; i++) lim[i] = LIM_RST[i];
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    pins_chk();
    chk(busy, 1'b0);
    for (int i = 0; i < 8; i++) rd(8'ha0 + 8'(2*i), 16'(LIM_RST[i]));
    rd(CMD_HW_CFG_RD, 16'(HW_CFG_RST));
    rd(CMD_SW_CFG_RD, 16'(SW_CFG_RST));
    for (int i = 0; i < 8; i++) wr(8'h20 + 8'(2*i), 16'($random(seed)));
    for (int i = 0; i < 8; i++) rd(8'ha0 + 8'(2*i), 16'(lim[i]));
    rd(8'hfe, 16'h0000);
    // each busy source alone
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      src <= 4'h1 << i;
      repeat (2) @(posedge core_clk);
      #1;
      chk(busy, 1'b1);
      @(posedge core_clk);
      src <= 4'h0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(busy, 1'b0);
    end
    // a low clock enable freezes busy against a new source
    @(posedge core_clk);
    clk_en <= 1'b0;
    src <= 4'h1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(busy, 1'b0);
    @(posedge core_clk);
    src <= 4'h0;
    clk_en <= 1'b1;
    pulse(0);
    chk(busy, 1'b0);
    pulse(1);
    chk(busy, 1'b1);
    rd(CMD_SW_CFG_RD, 16'(sw));
    result(2'h2, 12'h010, 1'b0);
    chk(busy, 1'b0);
    // scan selects 0 and 1, started from the pin once busy is low
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      conv_sel <= 2'(s);
      cstart <= 1'b1;
      repeat (6) @(posedge core_clk);
      cstart <= 1'b0;
      pulse(1);
      chk(busy, 1'b1);
      result(2'h1, 12'h000, 1'b0);
      chk(busy, 1'b1);
      pulse(1);
      result(2'h3, 12'h000, 1'b1);
      chk(busy, 1'b0);
      pulse(1);
      chk(busy, 1'b0);
    end
    @(posedge core_clk);
    cont <= 1'b1;
    pulse(0);
    pulse(1);
    chk(busy, 1'b0);
    @(posedge core_clk);
    cont <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(busy, 1'b1);
    result(2'h0, 12'h000, 1'b1);
    chk(busy, 1'b0);
    // neutral limits and readings clear every fault
    wr(CMD_SW_CFG_WR, 16'h000d);
    for (int k = 0; k < 4; k++) begin
      wr(8'h20 + 8'(4*k), (k % 2) ? 16'h0fff : 16'h07ff);
      wr(8'h22 + 8'(4*k), (k % 2) ? 16'h0000 : 16'h0800);
      result(2'(k), (k % 2) ? 12'h800 : 12'h000, 1'b0);
    end
    wr(8'h20, 16'hf100);
    wr(8'h22, 16'h0f80);
    result(2'h0, 12'h101, 1'b0);
    result(2'h0, 12'h0fa, 1'b0);
    result(2'h0, 12'h0f8, 1'b0);
    result(2'h0, 12'hff0, 1'b0);
    result(2'h0, 12'hf7f, 1'b0);
    result(2'h3, 12'h000, 1'b0);
    result(2'h0, 12'h000, 1'b0);
    result(2'h3, 12'h800, 1'b0);
    wr(CMD_SW_CFG_WR, 16'h003d);
    result(2'h0, 12'h101, 1'b0);
    result(2'h0, 12'h0c1, 1'b0);
    result(2'h0, 12'h0c0, 1'b0);
    wr(CMD_SW_CFG_WR, 16'h000c);
    result(2'h0, 12'h101, 1'b0);
    result(2'h0, 12'h100, 1'b0);
    result(2'h0, 12'h0ff, 1'b0);
    // interrupt behaviour: alarm holds until the flags are read
    u_bam_host.frame(CMD_FLAG_RD, 16'h0000, r);
    flags = 4'h0;
    wr(CMD_SW_CFG_WR, 16'h000e);
    result(2'h0, 12'h101, 1'b0);
    result(2'h0, 12'h0ff, 1'b0);
    rd(CMD_FLAG_RD, 16'h0001);
    flags = 4'h0;
    repeat (8) @(posedge core_clk);
    #1;
    pins_chk();
    // every drive configuration with channel one faulted
    wr(CMD_SW_CFG_WR, 16'h000c);
    result(2'h0, 12'h101, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(CMD_HW_CFG_WR, 16'(i));
      pins_chk();
      rd(CMD_HW_CFG_RD, 16'(i));
    end
    chk(16'(u_bam_host.oe_err), 16'h0000);
    tally_and_finish();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
